/* design/pcec_classifier.sv */
// Link error detection, classification, status and upstream reporting.
// Operation
// - Receive traffic is checked and every detected fault is classified before it is reported.
// - A fatal receive error sets bit 2 of the device status register.
// - An upstream error message is sent only when its reporting enable is set, else suppressed.
// - Training, link protocol, flow control, malformed packet and overflow errors are fatal.
// - Receiver error, bad packet, bad link packet, replay timeout and rollover are correctable.
// - Poison, end-to-end CRC, unsupported, timeout, abort, unexpected, access faults are nonfatal.
// - A sent packet is replayed when no acknowledgement arrives within the allowed time.
// - Replay conditions come from the transmit side and receive faults from the receive side.
// - Errors caused by this endpoint's own transmitted traffic are not recorded in its status.
// - A request whose address hits no base address window is an unsupported request.
// - A request expecting a completion reports a timeout when none returns in time.
// - Detailed error types are readable through an advanced error reporting vector.
`default_nettype none
module pcec_classifier #(
  parameter int unsigned CPL_TIMEOUT = pcec_pkg::CPL_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic                                  clk_in,
  input  wire logic                                  reset_in,
  // Receive path events.
  input  wire pcec_pkg::pcec_fatal_ev_t              rx_fatal_in,
  input  wire pcec_pkg::pcec_unc_ev_t                rx_unc_in,
  input  wire pcec_pkg::pcec_cor_ev_t                rx_cor_in,
  // Incoming request address check.
  input  wire logic                                  rx_req_valid_in,
  input  wire logic [31:0]                           rx_req_addr_in,
  input  wire logic [pcec_pkg::NUM_BARS-1:0]         bar_enable_in,
  input  wire logic [pcec_pkg::NUM_BARS-1:0][31:0]   bar_base_in,
  input  wire logic [pcec_pkg::NUM_BARS-1:0][31:0]   bar_mask_in,
  // Transmit side tracking.
  input  wire logic                                  tx_tlp_sent_in,
  input  wire logic                                  rx_ack_in,
  input  wire logic                                  tx_np_req_in,
  input  wire logic                                  rx_cpl_in,
  // Device control and status clear.
  input  wire pcec_pkg::pcec_ctl_t                   dev_ctl_in,
  input  wire logic [pcec_pkg::STS_W-1:0]            sts_clr_in,
  input  wire logic [pcec_pkg::UNC_W-1:0]            unc_clr_in,
  input  wire logic [pcec_pkg::COR_W-1:0]            cor_clr_in,
  // Status outputs.
  output logic [pcec_pkg::STS_W-1:0]                 dev_status_out,
  output logic [pcec_pkg::UNC_W-1:0]                 aer_unc_out,
  output logic [pcec_pkg::COR_W-1:0]                 aer_cor_out,
  output logic                                       ur_detect_out,
  // Replay control.
  output logic                                       replay_req_out,
  output logic [pcec_pkg::REPLAY_NUM_W-1:0]          replay_num_out,
  // Upstream error message.
  output logic                                       msg_valid_out,
  output pcec_pkg::pcec_msg_t                        msg_code_out
);
  logic                                  unacked_r;
  logic [pcec_pkg::OUTST_W-1:0]          outst_r;
  logic                                  ack_expire;
  logic                                  cpl_expire;
  logic                                  bar_hit;
  logic                                  ur_ev;
  logic                                  rollover_ev;
  logic                                  any_fatal;
  logic                                  any_nonfatal;
  logic                                  any_cor;
  logic [pcec_pkg::UNC_W-1:0]            unc_set;
  logic [pcec_pkg::COR_W-1:0]            cor_set;
  logic [pcec_pkg::STS_W-1:0]            sts_set;
  logic                                  pend_fatal_r;
  logic                                  pend_nonfatal_r;
  logic                                  pend_cor_r;

  // Address decode against every enabled base address window.
  always_comb begin
    bar_hit = 1'b0;
    for (int i = 0; i < pcec_pkg::NUM_BARS; i++) begin
      if (bar_enable_in[i] &&
          ((rx_req_addr_in & bar_mask_in[i]) == (bar_base_in[i] & bar_mask_in[i]))) begin
        bar_hit = 1'b1;
      end
    end
  end
  assign ur_ev = rx_req_valid_in && !bar_hit;

  // Acknowledge watchdog for sent packets.
  pcec_timer #(
    .W          (pcec_pkg::ACK_TIMER_W),
    .LIMIT      (pcec_pkg::ACK_LIMIT_CYC)
  ) u_ack_timer (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .run_in     (unacked_r),
    .restart_in (tx_tlp_sent_in || rx_ack_in),
    .expire_out (ack_expire)
  );

  // Completion watchdog for outstanding requests.
  pcec_timer #(
    .W          (pcec_pkg::CPL_TIMER_W),
    .LIMIT      (CPL_TIMEOUT)
  ) u_cpl_timer (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .run_in     (outst_r != '0),
    .restart_in (tx_np_req_in || rx_cpl_in),
    .expire_out (cpl_expire)
  );

  // Unacknowledged state; a new send in the same cycle as an ack keeps it set.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      unacked_r <= 1'b0;
    end else if (tx_tlp_sent_in) begin
      unacked_r <= 1'b1;
    end else if (rx_ack_in) begin
      unacked_r <= 1'b0;
    end
  end

  // Replay request and replay counter; an ack resets the counter.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      replay_req_out <= 1'b0;
      replay_num_out <= pcec_pkg::REPLAY_NUM_RST;
    end else begin
      replay_req_out <= ack_expire;
      if (rx_ack_in) begin
        replay_num_out <= pcec_pkg::REPLAY_NUM_RST;
      end else if (ack_expire) begin
        replay_num_out <= replay_num_out + 2'h1;
      end
    end
  end
  assign rollover_ev = ack_expire && !rx_ack_in &&
                       (replay_num_out == pcec_pkg::REPLAY_NUM_LAST);

  // Outstanding non-posted requests; a timeout abandons them all.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      outst_r <= pcec_pkg::OUTST_RST;
    end else if (cpl_expire) begin
      outst_r <= pcec_pkg::OUTST_RST;
    end else if (tx_np_req_in && !rx_cpl_in && (outst_r != '1)) begin
      outst_r <= outst_r + 4'h1;
    end else if (rx_cpl_in && !tx_np_req_in && (outst_r != '0)) begin
      outst_r <= outst_r - 4'h1;
    end
  end

  // Classification into detailed vectors. Only receive checks and local timers feed
  // these, so faults in our own transmitted packets never reach the status.
  assign unc_set = {rx_fatal_in.training, rx_fatal_in.dll_proto, rx_fatal_in.fc_proto,
                    rx_fatal_in.malformed, rx_fatal_in.rx_overflow,
                    rx_unc_in.poisoned, rx_unc_in.ecrc, ur_ev, cpl_expire,
                    rx_unc_in.cpl_abort, rx_unc_in.unexp_cpl, rx_unc_in.acs_viol};
  assign cor_set = {rx_cor_in.rx_err, rx_cor_in.bad_tlp, rx_cor_in.bad_dllp,
                    ack_expire, rollover_ev};
  assign any_fatal    = |rx_fatal_in;
  assign any_nonfatal = (|rx_unc_in) || ur_ev || cpl_expire;
  assign any_cor      = (|rx_cor_in) || ack_expire || rollover_ev;

  // Summary bits for the device status register.
  always_comb begin
    sts_set = '0;
    sts_set[pcec_pkg::STS_CORR_BIT]     = any_cor;
    sts_set[pcec_pkg::STS_NONFATAL_BIT] = any_nonfatal;
    sts_set[pcec_pkg::STS_FATAL_BIT]    = any_fatal;
    sts_set[pcec_pkg::STS_UR_BIT]       = ur_ev;
  end

  // Sticky status flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dev_status_out <= pcec_pkg::STS_RST;
      aer_unc_out    <= pcec_pkg::UNC_RST;
      aer_cor_out    <= pcec_pkg::COR_RST;
    end else begin
      dev_status_out <= (dev_status_out & ~sts_clr_in) | sts_set;
      aer_unc_out    <= (aer_unc_out & ~unc_clr_in) | unc_set;
      aer_cor_out    <= (aer_cor_out & ~cor_clr_in) | cor_set;
    end
  end

  // One-cycle notice of an unsupported request.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ur_detect_out <= 1'b0;
    end else begin
      ur_detect_out <= ur_ev;
    end
  end

  // Pending messages, gated by the control enables; a sent message clears its flag.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pend_fatal_r    <= 1'b0;
      pend_nonfatal_r <= 1'b0;
      pend_cor_r      <= 1'b0;
    end else begin
      if (any_fatal && dev_ctl_in.fatal_en) begin
        pend_fatal_r <= 1'b1;
      end else if (pend_fatal_r) begin
        pend_fatal_r <= 1'b0;
      end
      if (((|rx_unc_in) || cpl_expire || (ur_ev && dev_ctl_in.ur_en)) &&
          dev_ctl_in.nonfatal_en) begin
        pend_nonfatal_r <= 1'b1;
      end else if (pend_nonfatal_r && !pend_fatal_r) begin
        pend_nonfatal_r <= 1'b0;
      end
      if (any_cor && dev_ctl_in.cor_en) begin
        pend_cor_r <= 1'b1;
      end else if (pend_cor_r && !pend_fatal_r && !pend_nonfatal_r) begin
        pend_cor_r <= 1'b0;
      end
    end
  end

  // Message issue, most severe first, one per cycle.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      msg_valid_out <= 1'b0;
      msg_code_out  <= pcec_pkg::PCEC_MSG_NONE;
    end else if (pend_fatal_r) begin
      msg_valid_out <= 1'b1;
      msg_code_out  <= pcec_pkg::PCEC_MSG_FATAL;
    end else if (pend_nonfatal_r) begin
      msg_valid_out <= 1'b1;
      msg_code_out  <= pcec_pkg::PCEC_MSG_NONFATAL;
    end else if (pend_cor_r) begin
      msg_valid_out <= 1'b1;
      msg_code_out  <= pcec_pkg::PCEC_MSG_COR;
    end else begin
      msg_valid_out <= 1'b0;
      msg_code_out  <= pcec_pkg::PCEC_MSG_NONE;
    end
  end
endmodule : pcec_classifier
`default_nettype wire

/* design/pcec_pkg.sv */
// Shared constants and event carriers for the link error classifier.
`default_nettype none
package pcec_pkg;
  // Clock rate and timing figures.
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned ACK_LIMIT_NS     = 1000;
  localparam int unsigned ACK_LIMIT_CYC    = (ACK_LIMIT_NS * CLK_MHZ) / 1000;
  localparam int unsigned CPL_TIMEOUT_US   = 50000;
  localparam int unsigned CPL_TIMEOUT_CYC  = CPL_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned CPL_TIMER_W      = 24;
  localparam int unsigned ACK_TIMER_W      = 8;

  // Device status register layout.
  localparam int unsigned STS_W            = 4;
  localparam int unsigned STS_CORR_BIT     = 0;
  localparam int unsigned STS_NONFATAL_BIT = 1;
  localparam int unsigned STS_FATAL_BIT    = 2;
  localparam int unsigned STS_UR_BIT       = 3;
  localparam logic [3:0]  STS_RST          = 4'h0;

  // Detailed error vectors and other widths.
  localparam int unsigned UNC_W            = 12;
  localparam int unsigned COR_W            = 5;
  localparam logic [11:0] UNC_RST          = 12'h000;
  localparam logic [4:0]  COR_RST          = 5'h00;
  localparam int unsigned REPLAY_NUM_W     = 2;
  localparam logic [1:0]  REPLAY_NUM_RST   = 2'h0;
  localparam logic [1:0]  REPLAY_NUM_LAST  = 2'h3;
  localparam int unsigned OUTST_W          = 4;
  localparam logic [3:0]  OUTST_RST        = 4'h0;
  localparam int unsigned NUM_BARS         = 2;

  // Upstream error message codes.
  typedef enum logic [1:0] {
    PCEC_MSG_NONE     = 2'b00,
    PCEC_MSG_COR      = 2'b01,
    PCEC_MSG_NONFATAL = 2'b10,
    PCEC_MSG_FATAL    = 2'b11
  } pcec_msg_t;

  // Receive path events that are always fatal.
  typedef struct packed {
    logic training;
    logic dll_proto;
    logic fc_proto;
    logic malformed;
    logic rx_overflow;
  } pcec_fatal_ev_t;

  // Receive path events that are uncorrectable but not fatal.
  typedef struct packed {
    logic poisoned;
    logic ecrc;
    logic cpl_abort;
    logic unexp_cpl;
    logic acs_viol;
  } pcec_unc_ev_t;

  // Receive path events that are correctable.
  typedef struct packed {
    logic rx_err;
    logic bad_tlp;
    logic bad_dllp;
  } pcec_cor_ev_t;

  // Device control reporting enables.
  typedef struct packed {
    logic cor_en;
    logic nonfatal_en;
    logic fatal_en;
    logic ur_en;
  } pcec_ctl_t;
endpackage : pcec_pkg
`default_nettype wire

/* design/pcec_timer.sv */
// Restartable watchdog timer that pulses when a limit is reached.
`default_nettype none
module pcec_timer #(
  parameter int unsigned W     = 8,
  parameter int unsigned LIMIT = 200
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic reset_in,
  // Control.
  input  wire logic run_in,
  input  wire logic restart_in,
  // Expiry.
  output logic      expire_out
);
  logic [W-1:0] cnt_r;

  // Counts while running; restart or idle returns the count to zero.
  always_ff @(posedge clk_in) begin
    if (reset_in || restart_in || !run_in) begin
      cnt_r      <= '0;
      expire_out <= 1'b0;
    end else if (cnt_r == W'(LIMIT - 1)) begin
      cnt_r      <= '0;
      expire_out <= 1'b1;
    end else begin
      cnt_r      <= cnt_r + W'(1);
      expire_out <= 1'b0;
    end
  end
endmodule : pcec_timer
`default_nettype wire

/* verif/pcec_checker.sv */
// Port assertions for the link error classifier.
`default_nettype none
module pcec_checker (
  // Clock and reset.
  input wire logic                     clk_in,
  input wire logic                     reset_in,
  // Watched inputs.
  input wire pcec_pkg::pcec_fatal_ev_t rx_fatal_in,
  input wire pcec_pkg::pcec_unc_ev_t   rx_unc_in,
  input wire pcec_pkg::pcec_cor_ev_t   rx_cor_in,
  input wire logic                     rx_req_valid_in,
  input wire logic                     rx_ack_in,
  input wire pcec_pkg::pcec_ctl_t      dev_ctl_in,
  input wire logic [3:0]               sts_clr_in,
  // Watched outputs.
  input wire logic [3:0]               dev_status_out,
  input wire logic [11:0]              aer_unc_out,
  input wire logic [4:0]               aer_cor_out,
  input wire logic                     ur_detect_out,
  input wire logic                     replay_req_out,
  input wire logic [1:0]               replay_num_out,
  input wire logic                     msg_valid_out,
  input wire pcec_pkg::pcec_msg_t      msg_code_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // All checks run on the core clock and pause in reset.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_fatal_ev;
    (rx_fatal_in != 5'h00) && dev_ctl_in.fatal_en;
  endsequence
  sequence s_fatal_msg;
    ##[2:3] msg_valid_out && (msg_code_out == pcec_pkg::PCEC_MSG_FATAL);
  endsequence
  chk_fatal_flag: assert property ((rx_fatal_in != 5'h00) |=> dev_status_out[2]
    && ((aer_unc_out[11:7] & $past(rx_fatal_in)) == $past(rx_fatal_in)))
    else $error("Fatal event did not set its flags.");
  chk_unc_class: assert property ((rx_unc_in != 5'h00) |=> dev_status_out[1]
    && (({aer_unc_out[6:5], aer_unc_out[2:0]} & $past(rx_unc_in)) == $past(rx_unc_in)))
    else $error("Nonfatal event did not set its flags.");
  chk_cor_class: assert property ((rx_cor_in != 3'h0) |=> dev_status_out[0]
    && ((aer_cor_out[4:2] & $past(rx_cor_in)) == $past(rx_cor_in)))
    else $error("Correctable event did not set its flags.");
  chk_fatal_msg: assert property (s_fatal_ev |-> s_fatal_msg)
    else $error("Enabled fatal event sent no fatal message.");
  chk_msg_gated: assert property ((!dev_ctl_in.fatal_en)[*3]
    |-> !(msg_valid_out && (msg_code_out == pcec_pkg::PCEC_MSG_FATAL)))
    else $error("Fatal message sent while disabled.");
  chk_sticky_hold: assert property ((sts_clr_in == 4'h0)
    |=> ((dev_status_out & $past(dev_status_out)) == $past(dev_status_out)))
    else $error("Status flag dropped without a clear.");
  chk_ur_flags: assert property (ur_detect_out |-> $past(rx_req_valid_in)
    && dev_status_out[3] && aer_unc_out[4])
    else $error("Unsupported request flags wrong.");
  chk_replay_step: assert property (replay_req_out |-> aer_cor_out[1]
    && (replay_num_out == $past(replay_num_out) + 2'h1))
    else $error("Replay did not count or flag.");
  chk_ack_clear: assert property (rx_ack_in |=> (replay_num_out == 2'h0))
    else $error("Acknowledge did not clear the replay count.");
endmodule : pcec_checker
bind pcec_classifier pcec_checker u_chk (.clk_in, .reset_in, .rx_fatal_in, .rx_unc_in,
  .rx_cor_in, .rx_req_valid_in, .rx_ack_in, .dev_ctl_in, .sts_clr_in, .dev_status_out,
  .aer_unc_out, .aer_cor_out, .ur_detect_out, .replay_req_out, .replay_num_out,
  .msg_valid_out, .msg_code_out);
`default_nettype wire

/* verif/pcec_link_partner.sv */
// Link partner model that acknowledges packets and returns completions.
`default_nettype none
module pcec_link_partner (
  // Clock, reset and answer control.
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       ans_en_in,
  input  wire logic [7:0] delay_in,
  // Traffic from the device and answers to it.
  input  wire logic       tx_tlp_sent_in,
  input  wire logic       tx_np_req_in,
  output logic            rx_ack_out,
  output logic            rx_cpl_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ack_cnt_r;
  logic [7:0] cpl_cnt_r;
  // Acknowledge a sent packet after the delay; stay silent when answers are off.
  always_ff @(posedge clk_in) begin
    rx_ack_out <= !reset_in && (ack_cnt_r == 8'h01);
    if (reset_in || !ans_en_in) begin
      ack_cnt_r <= 8'h00;
    end else if (tx_tlp_sent_in) begin
      ack_cnt_r <= delay_in;
    end else if (ack_cnt_r != 8'h00) begin
      ack_cnt_r <= ack_cnt_r - 8'h01;
    end
  end
  // Return a completion for a request after the delay.
  always_ff @(posedge clk_in) begin
    rx_cpl_out <= !reset_in && (cpl_cnt_r == 8'h01);
    if (reset_in || !ans_en_in) begin
      cpl_cnt_r <= 8'h00;
    end else if (tx_np_req_in) begin
      cpl_cnt_r <= delay_in;
    end else if (cpl_cnt_r != 8'h00) begin
      cpl_cnt_r <= cpl_cnt_r - 8'h01;
    end
  end
endmodule : pcec_link_partner
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the link error classifier.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clk_in;
  logic                     reset_in;
  pcec_pkg::pcec_fatal_ev_t rx_fatal_in;
  pcec_pkg::pcec_unc_ev_t   rx_unc_in;
  pcec_pkg::pcec_cor_ev_t   rx_cor_in;
  pcec_pkg::pcec_ctl_t      dev_ctl_in;
  pcec_pkg::pcec_msg_t      msg_code_out;
  logic [1:0][31:0]         bar_base_in;
  logic [1:0][31:0]         bar_mask_in;
  logic [31:0]              rx_req_addr_in;
  logic [11:0]              unc_clr_in;
  logic [11:0]              aer_unc_out;
  logic [4:0]               cor_clr_in;
  logic [4:0]               aer_cor_out;
  logic [3:0]               sts_clr_in;
  logic [3:0]               dev_status_out;
  logic [1:0]               bar_enable_in;
  logic [1:0]               replay_num_out;
  logic [1:0]               msg_last;
  logic [7:0]               delay;
  logic                     rx_req_valid_in, tx_tlp_sent_in, rx_ack_in, tx_np_req_in;
  logic                     rx_cpl_in, ur_detect_out, replay_req_out, msg_valid_out, ans_en;
  int                       miscompares, n_checks, rp_cnt, cyc;
  pcec_classifier #(.CPL_TIMEOUT(50)) dut (.clk_in, .reset_in, .rx_fatal_in, .rx_unc_in,
    .rx_cor_in, .rx_req_valid_in, .rx_req_addr_in, .bar_enable_in, .bar_base_in,
    .bar_mask_in, .tx_tlp_sent_in, .rx_ack_in, .tx_np_req_in, .rx_cpl_in, .dev_ctl_in,
    .sts_clr_in, .unc_clr_in, .cor_clr_in, .dev_status_out, .aer_unc_out, .aer_cor_out,
    .ur_detect_out, .replay_req_out, .replay_num_out, .msg_valid_out, .msg_code_out);
  pcec_link_partner peer (.clk_in, .reset_in, .ans_en_in(ans_en), .delay_in(delay),
    .tx_tlp_sent_in, .tx_np_req_in, .rx_ack_out(rx_ack_in), .rx_cpl_out(rx_cpl_in));
  // Clock of 5 ns period.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Note the last message and replay pulses, and cut a hang short.
  always @(posedge clk_in) begin
    if (msg_valid_out === 1'b1) msg_last <= msg_code_out;
    if (replay_req_out === 1'b1) rp_cnt++;
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task automatic pulse(input logic [12:0] ev);
    @(posedge clk_in);
    {rx_fatal_in, rx_unc_in, rx_cor_in} <= ev;
    @(posedge clk_in);
    {rx_fatal_in, rx_unc_in, rx_cor_in} <= 13'h0000;
    #1;
  endtask : pulse
  task automatic msg_is(input logic [1:0] c);
    step(4);
    chk(msg_last, c, "message");
    msg_last = 2'h0;
  endtask : msg_is
  task automatic clr_all;
    @(posedge clk_in);
    {sts_clr_in, unc_clr_in, cor_clr_in} <= '1;
    @(posedge clk_in);
    {sts_clr_in, unc_clr_in, cor_clr_in} <= '0;
    step(1);
    chk({aer_cor_out, aer_unc_out[10:0]}, 16'h0000, "cleared");
    chk({dev_status_out, aer_unc_out[11]}, 16'h0000, "cleared");
  endtask : clr_all
  // Only well-formed requests to assigned addresses are sent.
  task automatic xmit(input logic np, input logic ans);
    @(posedge clk_in);
    ans_en <= ans;
    {tx_np_req_in, tx_tlp_sent_in} <= np ? 2'h2 : 2'h1;
    @(posedge clk_in);
    {tx_np_req_in, tx_tlp_sent_in} <= 2'h0;
  endtask : xmit
  task automatic t_classes;
    int ub[5] = '{6, 5, 2, 1, 0};
    for (int i = 0; i < 5; i++) begin
      pulse(13'h1000 >> i);
      chk(dev_status_out, 4'h4, "fatal status");
      chk(aer_unc_out, 12'h800 >> i, "fatal detail");
      msg_is(pcec_pkg::PCEC_MSG_FATAL);
      clr_all;
      pulse(13'h0080 >> i);
      chk(aer_unc_out, 12'h001 << ub[i], "nonfatal detail");
      msg_is(pcec_pkg::PCEC_MSG_NONFATAL);
      clr_all;
    end
    for (int i = 0; i < 3; i++) begin
      pulse(13'h0004 >> i);
      chk({dev_status_out, aer_cor_out}, {4'h1, 5'h10 >> i}, "cor flags");
      msg_is(pcec_pkg::PCEC_MSG_COR);
      clr_all;
    end
    $display("test classes done");
  endtask : t_classes
  task automatic t_gate;
    @(posedge clk_in);
    dev_ctl_in <= 4'h0;
    pulse(13'h1fff);
    chk(dev_status_out, 4'h7, "all classes");
    msg_is(pcec_pkg::PCEC_MSG_NONE);
    clr_all;
    @(posedge clk_in);
    dev_ctl_in <= 4'hf;
    pulse(13'h0004);
    step(10);
    chk(dev_status_out, 4'h1, "held");
    @(posedge clk_in);
    rx_cor_in <= 3'h4;
    sts_clr_in <= 4'h1;
    @(posedge clk_in);
    rx_cor_in <= 3'h0;
    sts_clr_in <= 4'h0;
    step(4);
    chk(dev_status_out, 4'h1, "set beats clear");
    msg_is(pcec_pkg::PCEC_MSG_COR);
    clr_all;
    $display("test gate done");
  endtask : t_gate
  task automatic t_ur;
    logic [31:0] ad[4] = '{32'h2000_0ffc, 32'h2000_1000, 32'h1000_fff0, 32'h1000_0000};
    logic [3:0] ex = 4'ha;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      bar_enable_in <= (i == 3) ? 2'h2 : 2'h3;
      rx_req_addr_in <= ad[i];
      rx_req_valid_in <= 1'b1;
      @(posedge clk_in);
      rx_req_valid_in <= 1'b0;
      #1;
      chk({ur_detect_out, aer_unc_out[4]}, {2{ex[i]}}, "ur");
      chk(dev_status_out, ex[i] ? 4'ha : 4'h0, "ur status");
      msg_is(ex[i] ? pcec_pkg::PCEC_MSG_NONFATAL : pcec_pkg::PCEC_MSG_NONE);
      clr_all;
    end
    $display("test ur done");
  endtask : t_ur
  task automatic t_replay;
    int n;
    xmit(1'b0, 1'b1);
    step(260);
    chk(rp_cnt, 0, "prompt ack");
    xmit(1'b0, 1'b0);
    for (int k = 1; k < 5; k++) begin
      n = 0;
      do begin
        step(1);
        n++;
      end while (replay_req_out !== 1'b1 && n < 400);
      chk(n >= 190 && n <= 210, 1'b1, "replay time");
      chk(replay_num_out, k % 4, "replay count");
    end
    chk(aer_cor_out[1:0], 2'h3, "replay flags");
    xmit(1'b0, 1'b1);
    step(20);
    clr_all;
    $display("test replay done");
  endtask : t_replay
  task automatic t_cpl;
    delay = 8'h28;
    xmit(1'b1, 1'b1);
    step(100);
    chk(aer_unc_out[3], 1'b0, "answered");
    xmit(1'b1, 1'b0);
    step(70);
    chk({aer_unc_out[3], dev_status_out[1]}, 2'h3, "timeout");
    clr_all;
    $display("test completion done");
  endtask : t_cpl
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Reset, then run every scenario.
  initial begin
    {rx_fatal_in, rx_unc_in, rx_cor_in, rx_req_valid_in, tx_tlp_sent_in, tx_np_req_in} = '0;
    {sts_clr_in, unc_clr_in, cor_clr_in, rx_req_addr_in, msg_last, ans_en} = '0;
    dev_ctl_in = 4'hf;
    bar_enable_in = 2'h3;
    bar_base_in = {32'h2000_0000, 32'h1000_0000};
    bar_mask_in = {32'hffff_f000, 32'hffff_0000};
    delay = 8'h02;
    reset_in = 1'b1;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    step(1);
    chk({dev_status_out, aer_unc_out}, 16'h0000, "reset");
    t_classes;
    t_gate;
    t_ur;
    t_replay;
    t_cpl;
    conclude;
  end
endmodule : testbench
`default_nettype wire
